//--- src/dpm_port_host.sv
// controller of one port of the two-port memory with mailbox and flags
// assumes software on the plain register port and the memory pins outside
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - right port clears its interrupt by accessing 3fff
// - hold address and select until the conflict flag settles, then write
// - one master only when words are widened over several parts
// - every slave takes the master's conflict outputs as inhibits
// - depth expansion ANDs the bank conflict flags externally
// - slave conflict input high writes normally, low blocks writes
module dpm_port_host
   import dpm_host_pkg::*;
#(
   parameter bit IS_LEFT   = 1'b1,
   parameter int STALL_LIM = STALL_MAX
)
(
   input  wire logic                            clk,
   input  wire logic                            rst_n,
   input  wire logic [dpm_host_pkg::REG_AW-1:0] sw_addr,
   input  wire logic [dpm_host_pkg::SW_W-1:0]   sw_wdata,
   input  wire logic                            sw_wr,
   input  wire logic                            sw_rd,
   output var  logic [dpm_host_pkg::SW_W-1:0]   sw_rdata,
   output var  logic                            mem_select_n,
   output var  logic                            flag_space_select_n,
   output var  logic                            rw_n,
   output var  logic                            out_enable_n,
   output var  logic [dpm_host_pkg::ADDR_W-1:0] port_addr,
   output var  logic [dpm_host_pkg::DATA_W-1:0] data_out,
   output var  logic                            data_oe,
   input  wire logic [dpm_host_pkg::DATA_W-1:0] data_in,
   input  wire logic                            conflict_flag_n,
   input  wire logic                            mailbox_irq_n
);
   import dpm_host_pkg::*;

   localparam logic [ADDR_W-1:0] OWN_BOX = IS_LEFT ? BOX_LEFT : BOX_RIGHT;
   localparam logic [ADDR_W-1:0] FAR_BOX = IS_LEFT ? BOX_RIGHT : BOX_LEFT;
   localparam logic [TMR_W-1:0] T_SET = TMR_W'(SETTLE_CYC - 1);
   localparam logic [TMR_W-1:0] T_ACC = TMR_W'(ACCESS_CYC - 1);
   localparam logic [TMR_W-1:0] T_WP  = TMR_W'(WPULSE_CYC - 1);
   localparam logic [TMR_W-1:0] T_REC = TMR_W'(RECOV_CYC - 1);
   localparam logic [STL_W-1:0] STALL_END = STL_W'(STALL_LIM - 1);

   ////////////////////////////////////////////////////////////////////////
   // pin inputs
   logic [DATA_W+1:0] pins_s;
   logic [DATA_W-1:0] data_s;
   logic              conflict_ok_s;
   logic              irq_s_n;

   bit_sync #(.W(DATA_W + 2)) u_sync (
      .clk     (clk),
      .rst_n   (rst_n),
      .d       ({conflict_flag_n, mailbox_irq_n, data_in}),
      .rst_val ({(DATA_W + 2){1'b1}}),
      .q       (pins_s)
   );

   always_comb
   begin
      data_s        = pins_s[DATA_W-1:0];
      irq_s_n       = pins_s[DATA_W];
      // one master's output, ANDed across banks outside, is the whole inhibit
      conflict_ok_s = pins_s[DATA_W+1];
   end

   ////////////////////////////////////////////////////////////////////////
   // phase timer
   logic             tmr_load;
   logic [TMR_W-1:0] tmr_val;
   logic             tmr_done;

   phase_timer #(.W(TMR_W)) u_tmr (
      .clk   (clk),
      .rst_n (rst_n),
      .load  (tmr_load),
      .count (tmr_val),
      .done  (tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // state
   phase_t            ph_q, ph_d;
   logic              ce_q, ce_d;
   logic              sem_q, sem_d;
   logic              rwn_q, rwn_d;
   logic              oen_q, oen_d;
   logic              doe_q, doe_d;
   logic [ADDR_W-1:0] pa_q, pa_d;
   logic [DATA_W-1:0] po_q, po_d;
   logic              op_wr_q, op_wr_d;
   logic              op_flag_q, op_flag_d;
   logic [STL_W-1:0]  stall_q, stall_d;
   logic [ADDR_W-1:0] areg_q, areg_d;
   logic [DATA_W-1:0] wreg_q, wreg_d;
   logic [DATA_W-1:0] rd_q, rd_d;
   logic              conf_q, conf_d;
   logic              abort_q, abort_d;
   logic [SW_W-1:0]   rdat_q, rdat_d;
   logic              go;
   logic              conf_ev;
   logic              abort_ev;
   logic [SW_W-1:0]   status;

   always_comb
   begin
      go        = sw_wr && (sw_addr == REG_CMD) && (ph_q == PH_IDLE);
      ph_d      = ph_q;
      ce_d      = ce_q;
      sem_d     = sem_q;
      rwn_d     = rwn_q;
      oen_d     = oen_q;
      doe_d     = doe_q;
      pa_d      = pa_q;
      po_d      = po_q;
      op_wr_d   = op_wr_q;
      op_flag_d = op_flag_q;
      stall_d   = stall_q;
      rd_d      = rd_q;
      tmr_load  = 1'b0;
      tmr_val   = T_SET;
      conf_ev   = 1'b0;
      abort_ev  = 1'b0;
      unique case (ph_q)
         PH_IDLE:
         begin
            if (go)
            begin
               op_wr_d   = sw_wdata[CMD_WRITE];
               op_flag_d = sw_wdata[CMD_FLAG];
               pa_d      = areg_q;
               if (sw_wdata[CMD_BOX])
                  pa_d = sw_wdata[CMD_WRITE] ? FAR_BOX : OWN_BOX;
               // flag space keeps the memory select high
               ce_d     = sw_wdata[CMD_FLAG];
               sem_d    = !sw_wdata[CMD_FLAG];
               po_d     = wreg_q;
               doe_d    = sw_wdata[CMD_WRITE];
               stall_d  = '0;
               tmr_load = 1'b1;
               tmr_val  = T_SET;
               ph_d     = PH_SETUP;
            end
         end
         PH_SETUP:
         begin
            if (tmr_done)
            begin
               tmr_load = 1'b1;
               if (!op_wr_q)
               begin
                  oen_d   = 1'b0;
                  tmr_val = T_ACC;
                  ph_d    = PH_PULSE;
               end
               else if (op_flag_q)
               begin
                  // flags never see the conflict logic
                  rwn_d   = 1'b0;
                  tmr_val = T_WP;
                  ph_d    = PH_PULSE;
               end
               else
                  ph_d = PH_ARB;
            end
         end
         PH_ARB:
         begin
            if (conflict_ok_s)
            begin
               rwn_d    = 1'b0;
               tmr_load = 1'b1;
               tmr_val  = T_WP;
               ph_d     = PH_PULSE;
            end
            else
            begin
               // a held-low inhibit would hang the port, so give up
               conf_ev = 1'b1;
               stall_d = stall_q + 1'b1;
               if (stall_q == STALL_END)
               begin
                  abort_ev = 1'b1;
                  ce_d     = 1'b1;
                  doe_d    = 1'b0;
                  tmr_load = 1'b1;
                  tmr_val  = T_REC;
                  ph_d     = PH_RECOV;
               end
            end
         end
         PH_PULSE:
         begin
            if (!op_wr_q && !op_flag_q && !conflict_ok_s)
               conf_ev = 1'b1;
            if (tmr_done)
            begin
               if (!op_wr_q)
                  rd_d = data_s;
               rwn_d    = 1'b1;
               oen_d    = 1'b1;
               tmr_load = 1'b1;
               tmr_val  = T_REC;
               ph_d     = PH_RECOV;
            end
         end
         PH_RECOV:
         begin
            // address and data held one step past the write edge
            ce_d  = 1'b1;
            sem_d = 1'b1;
            if (tmr_done)
            begin
               doe_d = 1'b0;
               ph_d  = PH_IDLE;
            end
         end
         default:
            ph_d = PH_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ph_q      <= PH_IDLE;
         ce_q      <= 1'b1;
         sem_q     <= 1'b1;
         rwn_q     <= 1'b1;
         oen_q     <= 1'b1;
         doe_q     <= 1'b0;
         pa_q      <= ADDR_RST;
         po_q      <= WDATA_RST;
         op_wr_q   <= 1'b0;
         op_flag_q <= 1'b0;
         stall_q   <= '0;
         rd_q      <= WDATA_RST;
      end
      else
      begin
         ph_q      <= ph_d;
         ce_q      <= ce_d;
         sem_q     <= sem_d;
         rwn_q     <= rwn_d;
         oen_q     <= oen_d;
         doe_q     <= doe_d;
         pa_q      <= pa_d;
         po_q      <= po_d;
         op_wr_q   <= op_wr_d;
         op_flag_q <= op_flag_d;
         stall_q   <= stall_d;
         rd_q      <= rd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software registers
   always_comb
   begin
      status = '0;
      status[ST_BUSY]     = (ph_q != PH_IDLE);
      status[ST_MAIL]     = !irq_s_n;
      status[ST_CONFLICT] = conf_q;
      status[ST_ABORT]    = abort_q;
      status[ST_CONF_NOW] = !conflict_ok_s;
      areg_d = areg_q;
      wreg_d = wreg_q;
      if (sw_wr && sw_addr == REG_ADDR)
         areg_d = sw_wdata[ADDR_W-1:0];
      if (sw_wr && sw_addr == REG_WDATA)
         wreg_d = sw_wdata[DATA_W-1:0];
      // write one clears; a new event in the same cycle wins
      conf_d  = conf_q;
      abort_d = abort_q;
      if (sw_wr && sw_addr == REG_STATUS)
      begin
         if (sw_wdata[ST_CONFLICT])
            conf_d = 1'b0;
         if (sw_wdata[ST_ABORT])
            abort_d = 1'b0;
      end
      if (conf_ev)
         conf_d = 1'b1;
      if (abort_ev)
         abort_d = 1'b1;
      rdat_d = '0;
      if (sw_rd)
      begin
         unique case (sw_addr)
            REG_ADDR:   rdat_d = SW_W'(areg_q);
            REG_WDATA:  rdat_d = SW_W'(wreg_q);
            REG_STATUS: rdat_d = status;
            REG_RDATA:  rdat_d = SW_W'(rd_q);
            default:    rdat_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         areg_q  <= ADDR_RST;
         wreg_q  <= WDATA_RST;
         conf_q  <= 1'b0;
         abort_q <= 1'b0;
         rdat_q  <= '0;
      end
      else
      begin
         areg_q  <= areg_d;
         wreg_q  <= wreg_d;
         conf_q  <= conf_d;
         abort_q <= abort_d;
         rdat_q  <= rdat_d;
      end
   end

   always_comb
   begin
      sw_rdata            = rdat_q;
      mem_select_n        = ce_q;
      flag_space_select_n = sem_q;
      rw_n                = rwn_q;
      out_enable_n        = oen_q;
      port_addr           = pa_q;
      data_out            = po_q;
      data_oe             = doe_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   logic [TMR_W:0] ce_age_q;
   logic           box_rd_go;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ce_age_q <= '0;
      else if (ce_q || !$stable(pa_q))
         ce_age_q <= '0;
      else if (ce_age_q != '1)
         ce_age_q <= ce_age_q + 1'b1;
   end

   always_comb
   begin
      box_rd_go = go && sw_wdata[CMD_BOX] && !sw_wdata[CMD_WRITE]
                  && !sw_wdata[CMD_FLAG];
   end

   localparam int BOX_WAIT = 8;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_write_after_settle: assert property (
      $fell(rwn_q) && !ce_q |-> ce_age_q >= SETTLE_CYC)
      else $error("memory write began before select settled");

   a_write_not_flagged: assert property (
      $fell(rwn_q) && !ce_q |-> $past(conflict_ok_s))
      else $error("write pulse began while conflict flag low");

   a_addr_held_write: assert property (
      !rwn_q |-> $stable(pa_q) && (!ce_q || !sem_q) && doe_q)
      else $error("address or select moved during write pulse");

   a_write_pulse_len: assert property (
      $fell(rwn_q) |-> !rwn_q [*2] ##1 rwn_q)
      else $error("write pulse length wrong");

   a_mailbox_clear: assert property (
      box_rd_go |=> pa_q == OWN_BOX ##[1:BOX_WAIT] (!oen_q && !ce_q))
      else $error("mailbox acknowledge did not read own box");

   a_abort_stall: assert property (
      abort_ev |-> !conflict_ok_s && ph_q == PH_ARB ##1 ce_q && abort_q)
      else $error("abort without a held conflict flag");

   a_single_space: assert property (
      !(ce_q == 1'b0 && sem_q == 1'b0))
      else $error("memory and flag space selected together");

   c_write_done: cover property ($rose(rwn_q) && !ce_q);
   c_stall_then_write: cover property (conf_ev ##2 $fell(rwn_q));
   c_abort: cover property (abort_ev);
   c_flag_read: cover property (!sem_q && !oen_q);
endmodule // dpm_port_host
`default_nettype wire

//--- src/dpm_host_pkg.sv
// constants of the port controller for the two-port memory with mailboxes
// assumes a 100 MHz clk; pin times are rounded to whole cycles here
package dpm_host_pkg;

   localparam int CLK_NS      = 10;
   localparam int SYNC_STAGES = 2;
   // pin times in ns
   localparam int SETTLE_NS   = 20;
   localparam int ACCESS_NS   = 20;
   localparam int WPULSE_NS   = 20;
   localparam int RECOV_NS    = 10;
   // least times round up; synchroniser delay added where a pin is read
   localparam int SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
   localparam int ACCESS_CYC  = (ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
   localparam int WPULSE_CYC  = (WPULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RECOV_CYC   = (RECOV_NS + CLK_NS - 1) / CLK_NS;
   localparam int STALL_MAX   = 256;

   localparam int ADDR_W = 14;
   localparam int DATA_W = 9;
   localparam int REG_AW = 4;
   localparam int SW_W   = 16;
   localparam int TMR_W  = 4;
   localparam int STL_W  = 9;

   localparam logic [ADDR_W-1:0] BOX_LEFT  = 14'h3ffe;
   localparam logic [ADDR_W-1:0] BOX_RIGHT = 14'h3fff;

   // software register offsets
   localparam logic [REG_AW-1:0] REG_ADDR   = 4'h0;
   localparam logic [REG_AW-1:0] REG_WDATA  = 4'h1;
   localparam logic [REG_AW-1:0] REG_CMD    = 4'h2;
   localparam logic [REG_AW-1:0] REG_STATUS = 4'h3;
   localparam logic [REG_AW-1:0] REG_RDATA  = 4'h4;

   // command bits
   localparam int CMD_WRITE = 0;
   localparam int CMD_FLAG  = 1;
   localparam int CMD_BOX   = 2;
   // status bits
   localparam int ST_BUSY     = 0;
   localparam int ST_MAIL     = 1;
   localparam int ST_CONFLICT = 2;
   localparam int ST_ABORT    = 3;
   localparam int ST_CONF_NOW = 4;

   localparam logic [ADDR_W-1:0] ADDR_RST  = 14'h0000;
   localparam logic [DATA_W-1:0] WDATA_RST = 9'h000;

   typedef enum logic [2:0] {
      PH_IDLE  = 3'b000,
      PH_SETUP = 3'b001,
      PH_ARB   = 3'b010,
      PH_PULSE = 3'b011,
      PH_RECOV = 3'b100
   } phase_t;

endpackage

//--- src/bit_sync.sv
// two-flop synchroniser, one chain per bit
// assumes d comes from pins outside the clk domain
`timescale 1ns/1ps
`default_nettype none
module bit_sync
#(
   parameter int W = 1
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   input  wire logic [W-1:0] rst_val,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] hold_q;
   logic [1:0]   fill_q;

   // flops reset to constants; rst_val covers the first two samples instead
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_q[i] <= 1'b1;
               hold_q[i] <= 1'b1;
            end
            else
            begin
               meta_q[i] <= d[i];
               hold_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         fill_q <= 2'b00;
      else
         fill_q <= {fill_q[0], 1'b1};
   end

   always_comb
   begin
      q = fill_q[1] ? hold_q : rst_val;
   end
endmodule // bit_sync
`default_nettype wire

//--- src/phase_timer.sv
// loadable down counter; done while it stands at zero
// assumes load is a one-cycle request from the same clock
`timescale 1ns/1ps
`default_nettype none
module phase_timer
#(
   parameter int W = 4
)
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         load,
   input  wire logic [W-1:0] count,
   output var  logic         done
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   always_comb
   begin
      if (load)
         cnt_d = count;
      else if (cnt_q != '0)
         cnt_d = cnt_q - 1'b1;
      else
         cnt_d = cnt_q;
      done = (cnt_q == '0);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end
endmodule // phase_timer
`default_nettype wire

//--- bench/dpm_device_model.sv
// behavioural two-port memory part: mailboxes, conflict flags, eight flags
// assumes two port controllers on its pins; acts as the master part
`timescale 1ns/1ps
`default_nettype none
module dpm_device_model
(
   input  wire logic [1:0]                      sel_n,
   input  wire logic [1:0]                      fsel_n,
   input  wire logic [1:0]                      rw_n,
   input  wire logic [1:0]                      oe_n,
   input  wire logic                            inhibit_r,
   input  wire logic [dpm_host_pkg::ADDR_W-1:0] addr [2],
   input  wire logic [dpm_host_pkg::DATA_W-1:0] wdat [2],
   output var  logic [dpm_host_pkg::DATA_W-1:0] rdat [2],
   output var  logic [1:0]                      conflict_n,
   output var  logic [1:0]                      irq_n
);
   import dpm_host_pkg::*;
   logic [DATA_W-1:0] mem [0:16383];
   logic [DATA_W-1:0] last [2] = '{9'h0a5, 9'h15a};
   logic [1:0]        own [8] = '{default: 2'b00};
   logic [1:0]        pend [8] = '{default: 2'b00};
   logic [1:0]        rw_prev = 2'b11;
   logic [1:0]        sel_prev = 2'b11;
   logic [1:0]        rd_prev = 2'b00;
   realtime           t_sel [2] = '{0.0, 0.0};
   logic [2:0]        s;
   //////////////////////////////////////////////////////////////
   initial
   begin
      irq_n = 2'b11;
      conflict_n = 2'b11;
   end
   // one process drives every output once the initial block has set irq_n and conflict_n
   always @(sel_n, fsel_n, rw_n, oe_n, addr[0], addr[1], inhibit_r)
   begin
      for (int p = 0; p < 2; p++)
      begin
         if (!sel_n[p] && sel_prev[p])
            t_sel[p] = $realtime;
      end
      conflict_n = 2'b11;
      // the later select loses; a tie goes against the right port
      if (!sel_n[0] && !sel_n[1] && addr[0] == addr[1])
         conflict_n[t_sel[1] >= t_sel[0]] = 1'b0;
      if (inhibit_r)
         conflict_n[1] = 1'b0;
      for (int p = 0; p < 2; p++)
      begin
         s = addr[p][2:0];
         if (rw_n[p] && !rw_prev[p] && !sel_n[p] && conflict_n[p])
         begin
            mem[addr[p]] = wdat[p];
            if (addr[p] == (p == 0 ? BOX_RIGHT : BOX_LEFT))
               irq_n[1-p] = 1'b0;
         end
         if (rw_n[p] && !rw_prev[p] && !fsel_n[p] && sel_n[p])
         begin
            if (!wdat[p][0] && own[s] == 2'b00)
               own[s][p] = 1'b1;
            else if (!wdat[p][0] && !own[s][p])
               pend[s][p] = 1'b1;
            else if (wdat[p][0] && own[s][p])
            begin
               own[s] = pend[s] & ~(2'b01 << p);
               pend[s] = 2'b00;
            end
            else if (wdat[p][0])
               pend[s][p] = 1'b0;
         end
         if (!sel_n[p] && !oe_n[p] && addr[p] == (p == 0 ? BOX_LEFT : BOX_RIGHT))
            irq_n[p] = 1'b1;
         if (!oe_n[p] && !sel_n[p])
            rdat[p] = mem[addr[p]];
         else if (!oe_n[p] && !fsel_n[p] && !rd_prev[p])
            rdat[p] = {DATA_W{!own[s][p]}};
         else if (oe_n[p] || fsel_n[p])
            rdat[p] = ~last[p];
         if (!oe_n[p] && (!sel_n[p] || !fsel_n[p]))
            last[p] = rdat[p];
         rd_prev[p] = !oe_n[p] && !fsel_n[p];
      end
      rw_prev = rw_n;
      sel_prev = sel_n;
   end
endmodule // dpm_device_model
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench: left and right port controllers on one memory model
// assumes dpm_host_pkg and dpm_device_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dpm_host_pkg::*;
   typedef struct {string name; logic [15:0] exp; logic [15:0] mask;} note_t;
   localparam logic [15:0] M_MAIL = 16'h0001 << ST_MAIL;
   localparam logic [15:0] M_CONF = 16'h0001 << ST_CONFLICT;
   localparam logic [15:0] M_ABRT = 16'h0001 << ST_ABORT;
   logic              clk, rst_n, inhibit_r;
   logic [REG_AW-1:0] sw_addr [2];
   logic [SW_W-1:0]   sw_wdata [2];
   logic [SW_W-1:0]   seen [2];
   logic [1:0]        sw_wr, sw_rd, rd_d;
   wire  [SW_W-1:0]   sw_rdata [2];
   wire  [1:0]        sel_n, fsel_n, rw_n, oe_n, data_oe, conflict_n, irq_n;
   wire  [ADDR_W-1:0] addr [2];
   wire  [DATA_W-1:0] dout [2], rdat [2], bus [2];
   note_t             notes [$];
   note_t             n;
   int                num_errors = 0;
   int                tests_run = 0;
   int                cycles = 0;
   int                seed, r;
   logic [ADDR_W-1:0] a;
   logic [2:0]        fl;
   logic [3:0]        st;
   logic [3:0]        tbl [6];
   //////////////////////////////////////////////////////////////
   for (genvar p = 0; p < 2; p++)
   begin : g_port
      assign bus[p] = data_oe[p] ? dout[p] : rdat[p];
      dpm_port_host #(.IS_LEFT(p == 0), .STALL_LIM(16)) dpm_port_host_inst (
         .clk(clk), .rst_n(rst_n), .sw_addr(sw_addr[p]), .sw_wdata(sw_wdata[p]),
         .sw_wr(sw_wr[p]), .sw_rd(sw_rd[p]), .sw_rdata(sw_rdata[p]),
         .mem_select_n(sel_n[p]), .flag_space_select_n(fsel_n[p]), .rw_n(rw_n[p]),
         .out_enable_n(oe_n[p]), .port_addr(addr[p]), .data_out(dout[p]),
         .data_oe(data_oe[p]), .data_in(bus[p]), .conflict_flag_n(conflict_n[p]),
         .mailbox_irq_n(irq_n[p]));
   end
   dpm_device_model dpm_device_model_inst (
      .sel_n(sel_n), .fsel_n(fsel_n), .rw_n(rw_n), .oe_n(oe_n), .inhibit_r(inhibit_r),
      .addr(addr), .wdat(bus), .rdat(rdat), .conflict_n(conflict_n), .irq_n(irq_n));
   //////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [15:0] sv, input logic [15:0] ev);
      tests_run++;
      if (sv !== ev)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, ev, sv);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic reg_wr(input int p, input logic [3:0] ra, input logic [15:0] wd);
      @(posedge clk);
      sw_addr[p] <= ra;
      sw_wdata[p] <= wd;
      sw_wr[p] <= 1'b1;
      @(posedge clk);
      sw_wr[p] <= 1'b0;
   endtask
   // a zero mask marks a poll whose value is only kept, not compared
   task automatic reg_rd(input int p, input logic [3:0] ra, input string nm,
                         input logic [15:0] e, input logic [15:0] m);
      @(posedge clk);
      sw_addr[p] <= ra;
      sw_rd[p] <= 1'b1;
      notes.push_back('{nm, e & m, m});
      @(posedge clk);
      sw_rd[p] <= 1'b0;
   endtask
   task automatic access(input int p, input logic [13:0] aa, input logic [8:0] dd,
                         input logic [2:0] c);
      int k;
      reg_wr(p, REG_ADDR, {2'b00, aa});
      reg_wr(p, REG_WDATA, {7'h00, dd});
      reg_wr(p, REG_CMD, {13'h0000, c});
      k = 0;
      do
      begin
         reg_rd(p, REG_STATUS, "poll", 16'h0000, 16'h0000);
         @(posedge clk);
         #1;
         k++;
      end
      while (seen[p][ST_BUSY] !== 1'b0 && k < 60);
      check("idle", {15'h0000, seen[p][ST_BUSY]}, 16'h0000);
   endtask
   //////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever
         #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      for (int p = 0; p < 2; p++)
      begin
         if (rd_d[p])
         begin
            seen[p] = sw_rdata[p];
            n = notes.pop_front();
            if (n.mask != 16'h0000)
               check(n.name, sw_rdata[p] & n.mask, n.exp);
         end
      end
      rd_d <= sw_rd;
      cycles <= cycles + 1;
      // generous ceiling: the whole sequence needs under a thousand cycles
      if (cycles == 30000)
      begin
         num_errors++;
         test_done();
      end
   end
   initial
   begin
      seed = 32'h76fe5aea;
      rst_n = 1'b0;
      inhibit_r = 1'b0;
      sw_wr = 2'b00;
      sw_rd = 2'b00;
      rd_d = 2'b00;
      sw_addr = '{default: '0};
      sw_wdata = '{default: '0};
      tbl = '{4'b0001, 4'b1001, 4'b0110, 4'b0010, 4'b1101, 4'b0111};
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      reg_rd(0, REG_STATUS, "status", 16'h0000, 16'hffff);
      reg_rd(1, 4'hf, "unmapped", 16'h0000, 16'hffff);
      for (int i = 0; i < 3; i++)
      begin
         r = $random(seed);
         a = {1'b0, r[12:0]};
         access(i % 2, a, r[24:16], 3'b001);
         access(1 - i % 2, a, 9'h000, 3'b000);
         reg_rd(1 - i % 2, REG_RDATA, "rdata", {7'h00, r[24:16]}, 16'h01ff);
      end
      for (int p = 0; p < 2; p++)
      begin
         r = $random(seed);
         access(p, p == 0 ? BOX_RIGHT : BOX_LEFT, 9'h000, 3'b000);
         reg_rd(1 - p, REG_STATUS, "mail", 16'h0000, M_MAIL);
         access(p, 14'h0000, r[8:0], 3'b101);
         reg_rd(1 - p, REG_STATUS, "mail", M_MAIL, M_MAIL);
         access(1 - p, 14'h0000, 9'h000, 3'b100);
         reg_rd(1 - p, REG_RDATA, "box", {7'h00, r[8:0]}, 16'h01ff);
         reg_rd(1 - p, REG_STATUS, "mail", 16'h0000, M_MAIL);
      end
      r = $random(seed);
      a = {1'b0, r[12:0]};
      fork
         access(0, a, r[24:16], 3'b001);
         access(1, a, ~r[24:16], 3'b001);
      join
      reg_rd(0, REG_STATUS, "conflict", 16'h0000, M_CONF);
      reg_rd(1, REG_STATUS, "conflict", M_CONF, M_CONF);
      access(0, a, 9'h000, 3'b000);
      reg_rd(0, REG_RDATA, "stalled", {7'h00, ~r[24:16]}, 16'h01ff);
      reg_wr(1, REG_STATUS, M_CONF | M_ABRT);
      reg_rd(1, REG_STATUS, "cleared", 16'h0000, M_CONF | M_ABRT);
      fork
         access(0, a, 9'h000, 3'b000);
         access(1, a, r[24:16], 3'b001);
      join
      reg_rd(1, REG_STATUS, "conflict", M_CONF, M_CONF);
      reg_rd(0, REG_RDATA, "read", {7'h00, ~r[24:16]}, 16'h01ff);
      inhibit_r <= 1'b1;
      access(1, a, ~r[24:16], 3'b001);
      reg_rd(1, REG_STATUS, "held", 16'h0001 << ST_CONF_NOW, 16'h0001 << ST_CONF_NOW);
      inhibit_r <= 1'b0;
      reg_rd(1, REG_STATUS, "abort", M_ABRT, M_ABRT);
      access(0, a, 9'h000, 3'b000);
      reg_rd(0, REG_RDATA, "inhibit", {7'h00, r[24:16]}, 16'h01ff);
      r = $random(seed);
      fl = r[2:0];
      for (int i = 0; i < 6; i++)
      begin
         st = tbl[i];
         r = $random(seed);
         access(st[3], {r[13:3], fl}, {8'h00, st[2]}, 3'b011);
         for (int q = 0; q < 2; q++)
         begin
            r = $random(seed);
            access(q, {r[13:3], fl}, 9'h000, 3'b010);
            reg_rd(q, REG_RDATA, "flag", {7'h00, {9{st[1-q]}}}, 16'h01ff);
         end
      end
      repeat (3) @(posedge clk);
      test_done();
   end
endmodule // testbench
`default_nettype wire
